// ===== rtl/bsp_pkg.sv
/*
 * Shared constants and carrier types for the two-word burst SRAM port:
 * array geometry, lane layout, organisation straps and the pin bundle.
 * Assumes a single 100 MHz system clock that oversamples every pin.
 */
`default_nettype none

package bsp_pkg;

   // Array geometry: one word per index, words paired by the low index bit
   localparam int ADDR_W     = 6;
   localparam int DEPTH      = 64;
   localparam int DATA_W     = 36;
   localparam int LANES      = 4;
   localparam int LANE_W     = 9;
   localparam int NIB_W      = 4;
   localparam int NIBS       = 2;
   localparam int FIFO_DEPTH = 32;

   // Reset values and strap timing
   localparam logic       OE_RESET   = 1'h0;
   localparam logic [1:0] STRAP_WAIT = 2'h3;   // Cycles until the pin synchroniser is full

   // Width organisation, a static strap
   typedef enum logic [1:0] {
      ORG_X8,
      ORG_X9,
      ORG_X18,
      ORG_X36
   } bsp_org_e;

   typedef logic [DATA_W-1:0] bsp_word_t;
   typedef logic [ADDR_W-1:0] bsp_index_t;

   // Everything that arrives on a pin, carried through the synchroniser together
   typedef struct packed {
      logic                 kClk;
      logic                 kClkN;
      logic                 cClk;
      logic                 cClkN;
      logic                 addressLoadN;
      logic                 readSelect;
      bsp_index_t           addr;
      logic [LANES-1:0]     laneWriteMaskN;
      logic [NIBS-1:0]      nibbleWriteMaskN;
      bsp_word_t            dqIn;
      bsp_org_e             org;
   } bsp_pins_s;

   // One masked write word on its way to the array
   typedef struct packed {
      bsp_index_t index;
      bsp_word_t  data;
      bsp_word_t  bitEn;
   } bsp_wrword_s;

endpackage

`default_nettype wire

// ===== rtl/bsp_fifo.sv
/*
 * Parameterised flip-flop FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two; one clock, synchronous active-low reset.
 */
`default_nettype none

module bsp_fifo
   import bsp_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             clock,     // System clock
   input  wire logic             reset_n,   // Synchronous reset, active low
   input  wire logic [WIDTH-1:0] inData,    // Word offered for storage
   input  wire logic             inValid,   // Offer is present
   output logic                  inReady,   // Room for one more word
   output logic      [WIDTH-1:0] outData,   // Oldest stored word
   output logic                  outValid,  // A word is stored
   input  wire logic             outReady   // Drain takes the oldest word
);

   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] slot;
      logic [PW-1:0]               wrPtr;
      logic [PW-1:0]               rdPtr;
      logic [PW:0]                 count;
   } bsp_fifo_state_s;

   bsp_fifo_state_s state_q;
   bsp_fifo_state_s state_d;
   logic            push;
   logic            pop;

   // Full and empty come straight from the occupancy count
   assign inReady  = (state_q.count != (PW+1)'(DEPTH));
   assign outValid = (state_q.count != '0);
   assign outData  = state_q.slot[state_q.rdPtr];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   // Pointers wrap naturally because the depth is a power of two
   always_comb begin
      state_d = state_q;
      if (push) begin
         state_d.slot[state_q.wrPtr] = inData;
         state_d.wrPtr               = state_q.wrPtr + 1'b1;
      end
      if (pop) begin
         state_d.rdPtr = state_q.rdPtr + 1'b1;
      end
      if (push && !pop) begin
         state_d.count = state_q.count + 1'b1;
      end else if (pop && !push) begin
         state_d.count = state_q.count - 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

endmodule

`default_nettype wire

// ===== rtl/bsp_port.sv
/*
 * Device side of a double-data-rate SRAM port with two-word bursts.
 * Input and output clock pairs are oversampled pins; a FIFO buffers
 * write words ahead of a flip-flop array.
 * Assumes every pin clock runs at most a quarter of the system clock.
 */
// Function
// RULE1 - write: word one at next K, two at K#
// RULE2 - read words on C# then C next cycles
// RULE3 - wide widths: second index flips address LSB
// RULE4 - narrow widths: burst always index 0 then 1
// RULE5 - NOP tristates outputs; stopped clocks hold state
// RULE6 - outputs high impedance after power-up
// RULE7 - write on both K edges, read on output edges
// RULE8 - controller parks stopped clocks high, preferably
// RULE9 - masks sampled separately with each write word
// RULE10 - x8: nibble masks guard bits 3:0, 7:4
// RULE11 - x18: lane masks guard bits 8:0, 17:9
// RULE12 - x9: single lane mask guards whole word
// RULE13 - x36: four lane masks guard nine-bit lanes
// RULE14 - output clocks high at power-on select single clock
`default_nettype none

module bsp_port
   import bsp_pkg::*;
(
   input  wire logic              clock,            // System clock, 100 MHz
   input  wire logic              reset_n,          // Synchronous reset, active low
   input  wire logic              kClk,             // Positive input clock pin
   input  wire logic              kClkN,            // Negative input clock pin
   input  wire logic              cClk,             // Positive output clock pin
   input  wire logic              cClkN,            // Negative output clock pin
   input  wire logic              address_load_n,   // Command strobe, active low
   input  wire logic              readSelect,       // High read, low write
   input  wire logic [ADDR_W-1:0] addr,             // Burst address
   input  wire logic [LANES-1:0]  lane_write_mask_n,   // Lane masks, active low
   input  wire logic [NIBS-1:0]   nibble_write_mask_n, // Nibble masks, active low
   input  wire logic [DATA_W-1:0] dqIn,             // Data pin level
   output logic      [DATA_W-1:0] dqOut,            // Data driven onto the pins
   output logic                   dqOe,             // High while driving the pins
   input  wire bsp_org_e          org,              // Width organisation strap
   output logic                   writeBufReady     // Write buffer has room
);

   typedef struct packed {
      bsp_pins_s                   sync1;
      bsp_pins_s                   sync2;
      logic                        kPrev;
      logic                        kNPrev;
      logic                        oPosPrev;
      logic                        oNegPrev;
      logic [1:0]                  strapWait;
      logic                        strapDone;
      logic                        singleClk;
      logic                        wrArmed;
      logic                        wr2Armed;
      bsp_index_t                  wrIdx1;
      bsp_index_t                  wrIdx2;
      logic                        rdArmed;
      bsp_index_t                  rdIdx1;
      bsp_index_t                  rdIdx2;
      logic                        word1Pend;
      logic                        word2Pend;
      bsp_word_t                   rdWord1;
      bsp_word_t                   rdWord2;
      bsp_word_t                   dqOut;
      logic                        dqOe;
      logic [DEPTH-1:0][DATA_W-1:0] mem;
   } bsp_port_state_s;

   bsp_port_state_s state_q;
   bsp_port_state_s state_d;
   bsp_pins_s       pins;
   bsp_pins_s       s2;
   logic            kRise;
   logic            kNRise;
   logic            oPos;
   logic            oNeg;
   logic            oPosRise;
   logic            oNegRise;
   logic            cmdWrite;
   logic            cmdRead;
   logic            pushValid;
   bsp_wrword_s     pushWord;
   logic            drainValid;
   logic            drainReady;
   bsp_wrword_s     drainWord;

   // Expand the active-low masks of one data word into per-bit write enables
   function automatic bsp_word_t laneEnable(input bsp_org_e         o,
                                            input logic [LANES-1:0] lane,
                                            input logic [NIBS-1:0]  nib);
      bsp_word_t en;
      en = '0;
      case (o)
         ORG_X8: begin
            for (int i = 0; i < NIBS; i++) begin
               en[i*NIB_W +: NIB_W] = {NIB_W{!nib[i]}};   // [RULE10]
            end
         end
         ORG_X9: begin
            en[LANE_W-1:0] = {LANE_W{!lane[0]}};          // [RULE12]
         end
         ORG_X18: begin
            for (int i = 0; i < 2; i++) begin
               en[i*LANE_W +: LANE_W] = {LANE_W{!lane[i]}};   // [RULE11]
            end
         end
         ORG_X36: begin
            for (int i = 0; i < LANES; i++) begin
               en[i*LANE_W +: LANE_W] = {LANE_W{!lane[i]}};   // [RULE13]
            end
         end
         default: en = '0;
      endcase
      return en;
   endfunction

   // Array index of the first or second word of a burst
   function automatic bsp_index_t burstIndex(input bsp_org_e   o,
                                             input bsp_index_t a,
                                             input logic       second);
      if (o == ORG_X18 || o == ORG_X36) begin
         return a ^ {{(ADDR_W-1){1'b0}}, second};     // [RULE3]
      end
      return {a[ADDR_W-2:0], second};                 // [RULE4]
   endfunction

   // Bundle the pins for the synchroniser
   assign pins = '{kClk: kClk, kClkN: kClkN, cClk: cClk, cClkN: cClkN,
                   addressLoadN: address_load_n, readSelect: readSelect, addr: addr,
                   laneWriteMaskN: lane_write_mask_n,
                   nibbleWriteMaskN: nibble_write_mask_n, dqIn: dqIn, org: org};
   assign s2 = state_q.sync2;

   // Edge detection looks only at the second synchroniser stage
   assign kRise    = s2.kClk && !state_q.kPrev;
   assign kNRise   = s2.kClkN && !state_q.kNPrev;
   assign oPos     = state_q.singleClk ? s2.kClk : s2.cClk;     // [RULE7]
   assign oNeg     = state_q.singleClk ? s2.kClkN : s2.cClkN;
   assign oPosRise = oPos && !state_q.oPosPrev;
   assign oNegRise = oNeg && !state_q.oNegPrev;
   assign cmdWrite = kRise && !s2.addressLoadN && !s2.readSelect;
   assign cmdRead  = kRise && !s2.addressLoadN && s2.readSelect;

   // Write words are captured on K for the first and K# for the second
   always_comb begin
      pushValid      = 1'b0;
      pushWord.data  = s2.dqIn;
      pushWord.bitEn = laneEnable(s2.org, s2.laneWriteMaskN, s2.nibbleWriteMaskN);   // [RULE9]
      pushWord.index = state_q.wrIdx1;
      if (kRise && state_q.wrArmed) begin
         pushValid = 1'b1;                             // [RULE1]
      end else if (kNRise && state_q.wr2Armed) begin
         pushValid      = 1'b1;                        // [RULE1]
         pushWord.index = state_q.wrIdx2;
      end
   end

   // The array has one port: a read fetch stalls the drain for that cycle
   assign drainReady = !(kRise && state_q.rdArmed);

   bsp_fifo #(
      .WIDTH ($bits(bsp_wrword_s)),
      .DEPTH (FIFO_DEPTH)
   ) u_bsp_fifo (
      .clock    (clock),
      .reset_n  (reset_n),
      .inData   (pushWord),
      .inValid  (pushValid),
      .inReady  (writeBufReady),
      .outData  (drainWord),
      .outValid (drainValid),
      .outReady (drainReady)
   );

   // Next-state logic for the whole port
   always_comb begin
      state_d          = state_q;
      state_d.sync1    = pins;
      state_d.sync2    = state_q.sync1;
      state_d.kPrev    = s2.kClk;
      state_d.kNPrev   = s2.kClkN;
      state_d.oPosPrev = oPos;
      state_d.oNegPrev = oNeg;

      // Strap is caught once the synchroniser holds real pin levels
      if (!state_q.strapDone) begin
         if (state_q.strapWait == STRAP_WAIT) begin
            state_d.strapDone = 1'b1;
            state_d.singleClk = s2.cClk && s2.cClkN;   // [RULE14]
         end else begin
            state_d.strapWait = state_q.strapWait + 1'b1;
         end
      end

      // Drain one buffered word into the array, only masked bits change
      if (drainValid && drainReady) begin
         state_d.mem[drainWord.index] = (state_q.mem[drainWord.index] & ~drainWord.bitEn)
                                        | (drainWord.data & drainWord.bitEn);
      end

      // Second write word belongs to the K# edge after the first
      if (kNRise && state_q.wr2Armed) begin
         state_d.wr2Armed = 1'b0;
      end

      if (kRise) begin
         // First write word taken now, second expected on K#
         state_d.wr2Armed = state_q.wrArmed;
         // Read fetch one cycle after the command, both words at once
         if (state_q.rdArmed) begin
            state_d.rdWord1   = state_q.mem[state_q.rdIdx1];
            state_d.rdWord2   = state_q.mem[state_q.rdIdx2];
            state_d.word1Pend = 1'b1;
         end
         // A high load strobe is a no-operation
         state_d.wrArmed = cmdWrite;                   // [RULE5]
         state_d.rdArmed = cmdRead;
      end
      if (cmdWrite) begin
         state_d.wrIdx1 = burstIndex(s2.org, s2.addr, 1'b0);
         state_d.wrIdx2 = burstIndex(s2.org, s2.addr, 1'b1);
      end
      if (cmdRead) begin
         state_d.rdIdx1 = burstIndex(s2.org, s2.addr, 1'b0);
         state_d.rdIdx2 = burstIndex(s2.org, s2.addr, 1'b1);
      end

      // First read word launched on the negative output edge
      if (oNegRise && state_q.word1Pend) begin
         state_d.dqOut     = state_q.rdWord1;          // [RULE2]
         state_d.dqOe      = 1'b1;
         state_d.word1Pend = kRise && state_q.rdArmed;   // A fetch in this cycle wins
         state_d.word2Pend = 1'b1;
      end
      // Second word on the positive edge; with nothing left the pins float
      if (oPosRise) begin
         if (state_q.word2Pend) begin
            state_d.dqOut     = state_q.rdWord2;       // [RULE2]
            state_d.word2Pend = 1'b0;
         end else begin
            state_d.dqOe = 1'b0;                       // [RULE5]
         end
      end
   end

   // Power-up leaves the port deselected with the pins floating
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_q      <= '0;
         state_q.dqOe <= OE_RESET;                     // [RULE6]
      end else begin
         state_q <= state_d;
      end
   end

   assign dqOut = state_q.dqOut;
   assign dqOe  = state_q.dqOe;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   property p_reset_floats;
      @(posedge clock) disable iff (1'b0) !reset_n |=> !dqOe;
   endproperty
   a_reset_floats: assert property (p_reset_floats) else $error("driven after reset"); // [RULE6]
   property p_first_word;
      oNegRise && state_q.word1Pend |=> dqOe && dqOut == $past(state_q.rdWord1);
   endproperty
   a_first_word: assert property (p_first_word) else $error("first word late"); // [RULE2]
   property p_second_word;
      oPosRise && state_q.word2Pend |=> dqOe && dqOut == $past(state_q.rdWord2);
   endproperty
   a_second_word: assert property (p_second_word) else $error("second word late"); // [RULE2]
   property p_fetch;
      kRise && state_q.rdArmed |-> !drainReady ##1 state_q.word1Pend
         && state_q.rdWord2 == $past(state_q.mem[state_q.rdIdx2]);
   endproperty
   a_fetch: assert property (p_fetch) else $error("read fetch missed"); // [RULE2]
   property p_idle_float;
      oPosRise && !state_q.word2Pend |=> !dqOe;
   endproperty
   a_idle_float: assert property (p_idle_float) else $error("pins not released"); // [RULE5]
   property p_stopped_hold;
      !oPosRise && !oNegRise |=> $stable(dqOut) && $stable(dqOe);
   endproperty
   a_stopped_hold: assert property (p_stopped_hold) else $error("output moved idle"); // [RULE5]
   property p_write_capture;
      (kRise && state_q.wrArmed) || (kNRise && state_q.wr2Armed)
         |-> pushValid && pushWord.data == s2.dqIn;
   endproperty
   a_write_capture: assert property (p_write_capture) else $error("word not taken"); // [RULE1]
   property p_mask_each_word;
      kNRise && state_q.wr2Armed |-> pushWord.index == state_q.wrIdx2
         && (s2.org != ORG_X36 || pushWord.bitEn[8:0] == {9{!s2.laneWriteMaskN[0]}});
   endproperty
   a_mask_each_word: assert property (p_mask_each_word) else $error("late K# mask"); // [RULE9]
   property p_wide_order;
      cmdWrite && (s2.org == ORG_X18 || s2.org == ORG_X36)
         |=> state_q.wrIdx2 == (state_q.wrIdx1 ^ ADDR_W'(1)) && state_q.wrIdx1 == $past(s2.addr);
   endproperty
   a_wide_order: assert property (p_wide_order) else $error("wide order wrong"); // [RULE3]
   property p_narrow_order;
      cmdRead && (s2.org == ORG_X8 || s2.org == ORG_X9) |=> !state_q.rdIdx1[0]
         && state_q.rdIdx2[0] && state_q.rdIdx1[ADDR_W-1:1] == state_q.rdIdx2[ADDR_W-1:1];
   endproperty
   a_narrow_order: assert property (p_narrow_order) else $error("narrow order wrong"); // [RULE4]
   property p_x8_mask;
      pushValid && s2.org == ORG_X8 |-> pushWord.bitEn[7:4] == {4{!s2.nibbleWriteMaskN[1]}}
         && pushWord.bitEn[3:0] == {4{!s2.nibbleWriteMaskN[0]}} && pushWord.bitEn[35:8] == '0;
   endproperty
   a_x8_mask: assert property (p_x8_mask) else $error("nibble enables"); // [RULE10]
   property p_x18_mask;
      pushValid && s2.org == ORG_X18 |-> pushWord.bitEn[17:9] == {9{!s2.laneWriteMaskN[1]}}
         && pushWord.bitEn[8:0] == {9{!s2.laneWriteMaskN[0]}} && pushWord.bitEn[35:18] == '0;
   endproperty
   a_x18_mask: assert property (p_x18_mask) else $error("x18 enables"); // [RULE11]
   property p_x9_mask;
      pushValid && s2.org == ORG_X9 |-> pushWord.bitEn[8:0] == {9{!s2.laneWriteMaskN[0]}}
         && pushWord.bitEn[35:9] == '0;
   endproperty
   a_x9_mask: assert property (p_x9_mask) else $error("x9 enable"); // [RULE12]
   property p_x36_mask;
      pushValid && s2.org == ORG_X36 |-> pushWord.bitEn[35:27] == {9{!s2.laneWriteMaskN[3]}}
         && pushWord.bitEn[26:18] == {9{!s2.laneWriteMaskN[2]}};
   endproperty
   a_x36_mask: assert property (p_x36_mask) else $error("x36 enables"); // [RULE13]
   property p_array_merge;
      drainValid && drainReady |=> state_q.mem[$past(drainWord.index)]
         == (($past(state_q.mem[drainWord.index]) & ~$past(drainWord.bitEn))
             | ($past(drainWord.data) & $past(drainWord.bitEn)));
   endproperty
   a_array_merge: assert property (p_array_merge) else $error("lane merge wrong"); // [RULE13]

endmodule

`default_nettype wire

// ===== dv/bsp_ctrl_model.sv
/*
 * Controller model facing the burst SRAM port: makes both clock pairs,
 * drives commands, masks and write data one K period at a time.
 * Assumes its tasks are called from the system clock domain.
 */
`default_nettype none

module bsp_ctrl_model
   import bsp_pkg::*;
(
   input  wire logic              clock,               // System clock
   input  wire logic [DATA_W-1:0] dqOut,               // Port read data
   input  wire logic              dqOe,                // Port drives pins
   output logic                   kClk,                // K
   output logic                   kClkN,               // K#
   output logic                   cClk,                // C
   output logic                   cClkN,               // C#
   output logic                   address_load_n,      // Command strobe
   output logic                   readSelect,          // Read when high
   output logic      [ADDR_W-1:0] addr,                // Burst address
   output logic      [LANES-1:0]  lane_write_mask_n,   // Lane masks
   output logic      [NIBS-1:0]   nibble_write_mask_n, // Nibble masks
   output logic      [DATA_W-1:0] dqDrv                // Controller data drive
);
   timeunit 1ns;
   timeprecision 1ps;

   logic      singleClk;
   logic      seenOe;
   bsp_word_t seenData;

   // Sampled mid-cycle so readers never race the port's update
   always @(negedge clock) begin
      seenOe   <= dqOe;
      seenData <= dqOut;
   end

   initial begin
      {kClk, kClkN, cClk, cClkN} = 4'h5;
      {address_load_n, readSelect, addr} = '1;
      {nibble_write_mask_n, lane_write_mask_n} = '1;
      dqDrv = '0;
   end

   // Output clocks both high at power-on pick single-clock timing
   task automatic strap(input logic s);
      singleClk = s;
      {kClk, kClkN} <= 2'h1;
      {cClk, cClkN} <= s ? 2'h3 : 2'h1;
   endtask

   // Stopped clocks rest high for the quickest restart
   task automatic park();
      {kClk, kClkN, cClk, cClkN} <= 4'hF;
      repeat (4) @(posedge clock);
   endtask

   // Eight cycles: command and word one at K, word two at K#, each with
   // its own masks; data wiggles when not a write so stale levels show
   task automatic period(input logic loadN, input logic rd, input bsp_index_t a,
                         input logic wr, input bsp_word_t d0, input bsp_word_t d1,
                         input logic [5:0] s0, input logic [5:0] s1,
                         output logic oe0, output bsp_word_t q0,
                         output logic oe1, output bsp_word_t q1);
      address_load_n <= loadN;
      readSelect <= rd;
      addr <= a;
      {nibble_write_mask_n, lane_write_mask_n} <= s0;
      dqDrv <= wr ? d0 : ~dqDrv;
      @(posedge clock);
      {kClk, kClkN} <= 2'h2;
      if (!singleClk) {cClk, cClkN} <= 2'h2;
      repeat (3) @(posedge clock);
      oe0 = seenOe;
      q0 = seenData;
      {nibble_write_mask_n, lane_write_mask_n} <= s1;
      dqDrv <= wr ? d1 : ~dqDrv;
      @(posedge clock);
      {kClk, kClkN} <= 2'h1;
      if (!singleClk) {cClk, cClkN} <= 2'h1;
      repeat (3) @(posedge clock);
      oe1 = seenOe;
      q1 = seenData;
   endtask
endmodule

`default_nettype wire

// ===== dv/test_bsp_port.sv
/*
 * Self-checking bench for the burst SRAM port: per organisation it
 * writes, mask-writes and reads back bursts through the controller model.
 * Assumes one 100 MHz clock; odd passes strap single-clock timing.
 */
`default_nettype none

module test_bsp_port
   import bsp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [5:0] SEL_ALL = 6'h00; // All lanes and nibbles
   localparam logic [5:0] SEL0    = 6'h2A; // Nibble 0, lanes 0 and 2
   localparam logic [5:0] SEL1    = 6'h15; // Nibble 1, lanes 1 and 3

   logic             clock, reset_n, kClk, kClkN, cClk, cClkN;
   logic             address_load_n, readSelect, dqOe, writeBufReady, seenReady;
   bsp_org_e         org;
   bsp_index_t       addr;
   logic [LANES-1:0] laneMaskN;
   logic [NIBS-1:0]  nibMaskN;
   bsp_word_t        dqDrv, dqIn, dqOut;
   bsp_word_t        mem [DEPTH];
   int               error_cnt, num_checks;

   // Shared data pins: the port wins while it drives
   assign dqIn = dqOe ? dqOut : dqDrv;

   always @(negedge clock) seenReady <= writeBufReady;

   bsp_port u_bsp_port (.clock(clock), .reset_n(reset_n), .kClk(kClk), .kClkN(kClkN),
      .cClk(cClk), .cClkN(cClkN), .address_load_n(address_load_n), .readSelect(readSelect),
      .addr(addr), .lane_write_mask_n(laneMaskN), .nibble_write_mask_n(nibMaskN),
      .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .org(org), .writeBufReady(writeBufReady));

   bsp_ctrl_model u_bsp_ctrl_model (.clock(clock), .dqOut(dqOut), .dqOe(dqOe), .kClk(kClk),
      .kClkN(kClkN), .cClk(cClk), .cClkN(cClkN), .address_load_n(address_load_n),
      .readSelect(readSelect), .addr(addr), .lane_write_mask_n(laneMaskN),
      .nibble_write_mask_n(nibMaskN), .dqDrv(dqDrv));

   function automatic bsp_word_t wm(bsp_org_e o);
      return (o == ORG_X8) ? 36'h0_0000_00FF : (o == ORG_X9) ? 36'h0_0000_01FF :
             (o == ORG_X18) ? 36'h0_0003_FFFF : 36'hF_FFFF_FFFF;
   endfunction

   // Enables from active-low masks
   function automatic bsp_word_t en(bsp_org_e o, logic [5:0] s);
      bsp_word_t e;
      e = '0;
      for (int i = 0; i < LANES; i++) e[LANE_W*i +: LANE_W] = {LANE_W{~s[i]}};
      if (o == ORG_X8) e = {28'h000_0000, {4{~s[5]}}, {4{~s[4]}}};
      return e & wm(o);
   endfunction

   // Wide widths flip the low bit, narrow ones append it
   function automatic bsp_index_t idx(bsp_org_e o, bsp_index_t a, logic s);
      return (o == ORG_X8 || o == ORG_X9) ? {a[4:0], s} : {a[5:1], a[0] ^ s};
   endfunction

   task automatic check(input bsp_word_t seen, input bsp_word_t exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic do_reset(input bsp_org_e o, input logic s);
      reset_n <= 1'b0;
      org <= o;
      u_bsp_ctrl_model.strap(s);
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
      repeat (8) @(posedge clock);
      check(u_bsp_ctrl_model.seenOe, '0, "pins idle after reset");
      check(seenReady, 1, "buffer ready after reset");
   endtask

   // Command, then both data words one K period later
   task automatic wr_burst(input bsp_index_t a, input bsp_word_t d0, input bsp_word_t d1,
                           input logic [5:0] s0, input logic [5:0] s1);
      logic      o0, o1;
      bsp_word_t q0, q1;
      u_bsp_ctrl_model.period(1'b0, 1'b0, a, 1'b0, '0, '0, SEL_ALL, SEL_ALL, o0, q0, o1, q1);
      u_bsp_ctrl_model.period(1'b1, 1'b0, a, 1'b1, d0, d1, s0, s1, o0, q0, o1, q1);
      check(o1, '0, "pins idle during write");
      check(seenReady, 1, "buffer ready");
      mem[idx(org, a, 1'b0)] = (mem[idx(org, a, 1'b0)] & ~en(org, s0)) | (d0 & en(org, s0));
      mem[idx(org, a, 1'b1)] = (mem[idx(org, a, 1'b1)] & ~en(org, s1)) | (d1 & en(org, s1));
   endtask

   // Two reads back to back, clocks stopped mid-way, then idle
   task automatic rd_pair(input bsp_index_t ar, input bsp_index_t aw);
      logic      oe [5][2];
      bsp_word_t q [5][2];
      bsp_word_t m;
      m = wm(org);
      for (int p = 0; p < 5; p++) begin
         u_bsp_ctrl_model.period(p > 1, 1'b1, (p == 0) ? ar : aw, 1'b0, '0, '0, SEL_ALL,
                                 SEL_ALL, oe[p][0], q[p][0], oe[p][1], q[p][1]);
         if (p == 2) begin
            repeat (20) @(posedge clock);
            check(u_bsp_ctrl_model.seenData & m, mem[idx(org, aw, 1'b0)] & m, "stop");
         end
      end
      check(oe[1][1], '0, "early drive");
      check(oe[2][0], 1, "first read drive");
      check(q[2][0] & m, mem[idx(org, ar, 1'b0)] & m, "r1w1");
      check(q[2][1] & m, mem[idx(org, ar, 1'b1)] & m, "r1w2");
      check(oe[3][1], 1, "second read drive");
      check(q[3][1] & m, mem[idx(org, aw, 1'b1)] & m, "r2w2");
      check(oe[4][1], '0, "pins released");
   endtask

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Watchdog: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      give_verdict();
   end

   // Every organisation: fill, masked rewrite, read back; wide widths in both orders
   initial begin
      reset_n = 1'b0;
      org = ORG_X8;
      error_cnt = 0;
      num_checks = 0;
      for (int i = 0; i < 4; i++) begin
         do_reset(bsp_org_e'(i), i[0]);
         wr_burst(6'h2B, 36'hA_5A5A_5A5A, 36'h5_A5A5_A5A5, SEL_ALL, SEL_ALL);
         wr_burst(6'h2B, 36'hF_0F0F_3C3C, 36'h3_C3C3_0FF0, SEL0, SEL1);
         rd_pair((i < 2) ? 6'h0B : 6'h2A, 6'h2B);
         u_bsp_ctrl_model.park();
         $display("Organisation %0d done, mismatches %0d", i, error_cnt);
      end
      give_verdict();
   end
endmodule

`default_nettype wire
